// *** src/fss_pkg.sv ***
// Shared constants and carrier types for the filter sync settling timer.
package fss_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FIRST = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SETTLE_A = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SETTLE_B = 8'h14;

  // ----------------------------------------------------------------------
  // Control field layout
  // ----------------------------------------------------------------------
  localparam int CTRL_DIV_LO = 0;
  localparam int CTRL_FILT_BIT = 2;
  localparam int CTRL_BUSED_BIT = 3;
  localparam int CTRL_DECA_LO = 4;
  localparam int CTRL_DECB_LO = 8;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] DIV4 = 2'h0;
  localparam logic [1:0] DIV8 = 2'h1;
  localparam logic [1:0] DIV16 = 2'h2;
  localparam logic [1:0] DIV32 = 2'h3;
  localparam logic WBAND = 1'h0;
  localparam logic SINC5 = 1'h1;
  localparam logic [2:0] D32 = 3'h0;
  localparam logic [2:0] D64 = 3'h1;
  localparam logic [2:0] D128 = 3'h2;
  localparam logic [2:0] D256 = 3'h3;
  localparam logic [2:0] D512 = 3'h4;
  localparam logic [2:0] D1024 = 3'h5;
  localparam int DIV_SHIFT_BASE = 2;
  localparam int DEC_SHIFT_BASE = 5;

  // ----------------------------------------------------------------------
  // Delay widths
  // ----------------------------------------------------------------------
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hFF_FFFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;

  typedef struct packed {
    logic [2:0] dec_b;
    logic [2:0] dec_a;
    logic b_used;
    logic filt;
    logic [1:0] div;
  } fss_cfg_s;

  typedef struct packed {
    logic valid;
    logic [CNT_W-1:0] first;
    logic [CNT_W-1:0] settle_a;
    logic [CNT_W-1:0] settle_b;
  } fss_delay_s;

endpackage

// *** src/fss_timer.sv ***
// Sync-restart and settling-delay timer for the decimation filters.
//
// What the document requires
// R1: Sync rising edge restarts all decimation filters.
// R2: Host resyncs after power-up and reconfiguration.
// R3: First and settled results follow fixed delays.
// R4: Count master clocks from first edge after sync.
// R5: Wideband div4 32/64: first result at 758.
// R6: Same setup settles at 8822 and 17014.
// R7: Separate delay sets for single and mixed groups.
// R8: Host trusts data only after group settles.
//
// Added by the designer: the address map and the address-and-strobe port.
module fss_timer
  import fss_pkg::*;
#(
  parameter int P_DELAY_SHIFT = 0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Sync pin
  input wire logic i_sync,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Filter timing outputs
  output logic o_filter_restart,
  output logic o_data_ready_strobe,
  output logic o_settled_a,
  output logic o_settled_b,
  output logic o_cfg_err
);

  // ----------------------------------------------------------------------
  // Delay table
  // ----------------------------------------------------------------------
  // The table holds only the configurations whose delays are known; any
  // other setting is flagged and produces no data-ready strobes after its sync edge,
  // rather than guessing a delay that could mislead the host.
  function automatic fss_delay_s ent(input int f, input int a, input int b);
    fss_delay_s r;
    r.valid = 1'b1;
    r.first = CNT_W'(f);
    r.settle_a = CNT_W'(a);
    r.settle_b = CNT_W'(b);
    return r;
  endfunction

  function automatic fss_delay_s lookup(input fss_cfg_s c);
    fss_delay_s r;
    r = '0;
    if (!c.b_used) begin
      case ({c.div, c.filt, c.dec_a}) // R7
        {DIV4, WBAND, D32}: r = ent(336, 8400, 0);
        {DIV4, WBAND, D64}: r = ent(620, 16748, 0);
        {DIV4, WBAND, D128}: r = ent(1187, 33443, 0);
        {DIV4, WBAND, D256}: r = ent(2325, 66837, 0);
        {DIV4, WBAND, D512}: r = ent(4601, 133625, 0);
        {DIV4, WBAND, D1024}: r = ent(9153, 267201, 0);
        {DIV8, WBAND, D32}: r = ent(656, 16784, 0);
        {DIV8, WBAND, D64}: r = ent(1225, 33481, 0);
        {DIV8, WBAND, D128}: r = ent(2359, 66871, 0);
        {DIV8, WBAND, D256}: r = ent(4635, 133659, 0);
        {DIV8, WBAND, D512}: r = ent(9187, 267235, 0);
        {DIV8, WBAND, D1024}: r = ent(18291, 534387, 0);
        {DIV32, WBAND, D32}: r = ent(2587, 67099, 0);
        {DIV32, WBAND, D64}: r = ent(4855, 133879, 0);
        {DIV32, WBAND, D128}: r = ent(9391, 267439, 0);
        {DIV32, WBAND, D256}: r = ent(18495, 534591, 0);
        {DIV32, WBAND, D512}: r = ent(36703, 1068895, 0);
        {DIV32, WBAND, D1024}: r = ent(73119, 2137503, 0);
        {DIV4, SINC5, D32}: r = ent(199, 839, 0);
        {DIV4, SINC5, D64}: r = ent(327, 1607, 0);
        {DIV4, SINC5, D128}: r = ent(583, 3143, 0);
        {DIV4, SINC5, D256}: r = ent(1095, 6215, 0);
        {DIV4, SINC5, D512}: r = ent(2119, 12359, 0);
        {DIV4, SINC5, D1024}: r = ent(4167, 24647, 0);
        default: r = '0;
      endcase
    end else begin
      case ({c.div, c.filt, c.dec_a, c.dec_b}) // R7
        {DIV4, WBAND, D32, D32}: r = ent(758, 8822, 8822);
        {DIV4, WBAND, D32, D64}: r = ent(758, 8822, 17014); // R5 R6
        {DIV4, WBAND, D32, D128}: r = ent(758, 8822, 33526);
        {DIV4, WBAND, D32, D256}: r = ent(758, 8822, 66934);
        {DIV4, WBAND, D32, D512}: r = ent(758, 8822, 133622);
        {DIV4, WBAND, D32, D1024}: r = ent(758, 8822, 267253);
        {DIV4, WBAND, D64, D32}: r = ent(759, 17015, 8823);
        {DIV4, WBAND, D128, D32}: r = ent(760, 33528, 8824);
        {DIV4, WBAND, D256, D32}: r = ent(762, 66938, 8826);
        {DIV4, WBAND, D512, D32}: r = ent(782, 133646, 8846);
        {DIV4, WBAND, D1024, D32}: r = ent(806, 267302, 8870);
        {DIV8, WBAND, D32, D32}: r = ent(820, 16948, 16948);
        {DIV8, WBAND, D32, D64}: r = ent(820, 16948, 33588);
        {DIV8, WBAND, D32, D128}: r = ent(820, 16948, 66868);
        {DIV8, WBAND, D32, D256}: r = ent(820, 16948, 133684);
        {DIV8, WBAND, D32, D512}: r = ent(820, 16948, 267316);
        {DIV8, WBAND, D32, D1024}: r = ent(820, 16948, 534580);
        {DIV8, WBAND, D64, D32}: r = ent(822, 33590, 16950);
        {DIV8, WBAND, D128, D32}: r = ent(824, 66872, 16952);
        {DIV8, WBAND, D256, D32}: r = ent(844, 133708, 16972);
        {DIV8, WBAND, D512, D32}: r = ent(836, 267332, 16964);
        {DIV8, WBAND, D1024, D32}: r = ent(852, 534612, 16980);
        {DIV32, WBAND, D32, D32}: r = ent(2587, 67099, 67099);
        {DIV32, WBAND, D32, D64}: r = ent(2587, 67099, 134683);
        {DIV32, WBAND, D32, D128}: r = ent(2587, 67099, 267803);
        {DIV32, WBAND, D32, D256}: r = ent(2587, 67099, 535067);
        {DIV32, WBAND, D32, D512}: r = ent(2587, 67099, 1069595);
        {DIV32, WBAND, D32, D1024}: r = ent(2587, 67099, 2137627);
        {DIV32, WBAND, D64, D32}: r = ent(2587, 134683, 67099);
        {DIV32, WBAND, D128, D32}: r = ent(2587, 267803, 67099);
        {DIV32, WBAND, D256, D32}: r = ent(2587, 535067, 67099);
        {DIV32, WBAND, D512, D32}: r = ent(2587, 1069595, 67099);
        {DIV32, WBAND, D1024, D32}: r = ent(2587, 2137627, 67099);
        {DIV4, SINC5, D32, D32}: r = ent(199, 839, 839);
        {DIV4, SINC5, D32, D64}: r = ent(199, 839, 1607);
        default: r = '0;
      endcase
    end
    return r;
  endfunction

  // Shortens a tabulated delay for simulation; never below one cycle.
  function automatic logic [CNT_W-1:0] scale(input logic [CNT_W-1:0] d);
    logic [CNT_W-1:0] s;
    s = d >> P_DELAY_SHIFT;
    if (s == CNT_ZERO) begin
      s = CNT_ONE;
    end
    return s;
  endfunction

  // ----------------------------------------------------------------------
  // Configuration and lookup
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] ctrl;
  logic [DATA_W-1:0] next_ctrl;
  fss_cfg_s cfg;
  fss_delay_s dly;
  logic [CNT_W-1:0] first_d;
  logic [CNT_W-1:0] set_a_d;
  logic [CNT_W-1:0] set_b_d;
  logic [2:0] dec_fast;
  logic [CNT_W-1:0] odr_period;

  always_comb begin
    cfg.div = ctrl[CTRL_DIV_LO +: 2];
    cfg.filt = ctrl[CTRL_FILT_BIT];
    cfg.b_used = ctrl[CTRL_BUSED_BIT];
    cfg.dec_a = ctrl[CTRL_DECA_LO +: 3];
    cfg.dec_b = ctrl[CTRL_DECB_LO +: 3];
    dly = lookup(cfg); // R3
    first_d = scale(dly.first);
    set_a_d = scale(dly.settle_a);
    set_b_d = scale(dly.settle_b);
    // Data-ready follows the faster of the two groups once running.
    dec_fast = cfg.dec_a;
    if (cfg.b_used && (cfg.dec_b < cfg.dec_a)) begin
      dec_fast = cfg.dec_b;
    end
    odr_period = scale(CNT_ONE << (DIV_SHIFT_BASE + int'(cfg.div) +
                                   DEC_SHIFT_BASE + int'(dec_fast)));
  end

  // ----------------------------------------------------------------------
  // Sync edge and settling counter
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_FIRST,
    ST_RUN
  } fss_state_e;

  fss_state_e state;
  fss_state_e next_state;
  logic sync_prev;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] phase;
  logic [CNT_W-1:0] next_phase;
  logic next_restart;
  logic next_strobe;
  logic next_set_a;
  logic next_set_b;
  logic sync_rise;

  assign sync_rise = i_sync && !sync_prev;

  always_comb begin
    next_state = state;
    next_count = count;
    next_phase = phase;
    next_restart = 1'b0;
    next_strobe = 1'b0;
    next_set_a = o_settled_a;
    next_set_b = o_settled_b;
    if (sync_rise) begin
      // History before the edge is dropped: counter and flags start over.
      next_restart = 1'b1; // R1
      next_count = CNT_ONE; // R4
      next_phase = CNT_ZERO;
      next_set_a = 1'b0;
      next_set_b = 1'b0;
      next_state = dly.valid ? ST_WAIT_FIRST : ST_IDLE;
    end else begin
      if (state != ST_IDLE && count != CNT_MAX) begin
        next_count = count + CNT_ONE; // R4
      end
      case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_WAIT_FIRST: begin
          if (count == first_d) begin
            next_strobe = 1'b1; // R3
            // Reloading the full period makes the next strobe land exactly
            // one output period later, as phase counts down to one.
            next_phase = odr_period;
            next_state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (phase == CNT_ONE) begin
            next_strobe = 1'b1;
            next_phase = odr_period;
          end else begin
            next_phase = phase - CNT_ONE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
      if (state != ST_IDLE && count == set_a_d) begin
        next_set_a = 1'b1; // R6
      end
      if (state != ST_IDLE && cfg.b_used && count == set_b_d) begin
        next_set_b = 1'b1; // R6
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
      sync_prev <= 1'b0;
      count <= CNT_ZERO;
      phase <= CNT_ZERO;
      o_filter_restart <= 1'b0;
      o_data_ready_strobe <= 1'b0;
      o_settled_a <= 1'b0;
      o_settled_b <= 1'b0;
    end else begin
      state <= next_state;
      sync_prev <= i_sync;
      count <= next_count;
      phase <= next_phase;
      o_filter_restart <= next_restart;
      o_data_ready_strobe <= next_strobe;
      o_settled_a <= next_set_a;
      o_settled_b <= next_set_b;
    end
  end

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  // A control write does not restart the timer; the host is expected to
  // give a fresh sync edge after any reconfiguration.
  logic [DATA_W-1:0] next_rdata;
  logic next_cfg_err;

  always_comb begin
    next_ctrl = ctrl;
    next_rdata = '0;
    if (i_wr && i_addr == OFS_CTRL) begin
      next_ctrl = i_wdata;
    end
    if (i_rd) begin
      case (i_addr)
        OFS_CTRL: next_rdata = ctrl;
        OFS_STATUS: next_rdata = {27'h000_0000, state == ST_RUN,
                                  o_settled_b, o_settled_a, !dly.valid,
                                  state != ST_IDLE};
        OFS_COUNT: next_rdata = {8'h00, count};
        OFS_FIRST: next_rdata = {8'h00, first_d};
        OFS_SETTLE_A: next_rdata = {8'h00, set_a_d};
        OFS_SETTLE_B: next_rdata = {8'h00, set_b_d};
        default: next_rdata = '0;
      endcase
    end
    next_cfg_err = !dly.valid;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= CTRL_RESET;
      o_rdata <= '0;
      o_cfg_err <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      o_rdata <= next_rdata;
      o_cfg_err <= next_cfg_err;
    end
  end

endmodule

// *** bench/fss_timer_assertions.sv ***
// Concurrent checks on the ports of the sync settling timer.
module fss_timer_checker
  import fss_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_sync,
  input wire logic o_filter_restart,
  input wire logic o_data_ready_strobe,
  input wire logic o_settled_a,
  input wire logic o_settled_b,
  input wire logic o_cfg_err
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_restart;
    $rose(i_sync) |=> o_filter_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_cause;
    o_filter_restart |-> $past(i_sync) && !$past(i_sync, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("stray restart");
  property p_one;
    o_filter_restart |=> !o_filter_restart;
  endproperty
  a_one: assert property (p_one) else $error("long restart");
  property p_clear;
    o_filter_restart |-> !o_settled_a && !o_settled_b;
  endproperty
  a_clear: assert property (p_clear) else $error("flags kept");
  property p_quiet;
    o_filter_restart |-> (!o_data_ready_strobe) [*8];
  endproperty
  a_quiet: assert property (p_quiet) else $error("early strobe");
  property p_err;
    o_filter_restart && o_cfg_err |-> !(o_data_ready_strobe || o_settled_a) [*8];
  endproperty
  a_err: assert property (p_err) else $error("bad config ran");
  property p_pulse;
    o_data_ready_strobe |=> !o_data_ready_strobe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  property p_hold_a;
    o_settled_a |=> o_settled_a || o_filter_restart;
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("settled a lost");
  property p_hold_b;
    o_settled_b |=> o_settled_b || o_filter_restart;
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("settled b lost");
  c_strobe: cover property (o_data_ready_strobe);
  c_set_b: cover property (o_settled_b);
  c_err: cover property (o_filter_restart && o_cfg_err);
endmodule

bind fss_timer fss_timer_checker fss_timer_checker_i (.i_clk(i_clk),
  .i_resetn(i_resetn), .i_sync(i_sync), .o_filter_restart(o_filter_restart),
  .o_data_ready_strobe(o_data_ready_strobe), .o_settled_a(o_settled_a),
  .o_settled_b(o_settled_b), .o_cfg_err(o_cfg_err));

// *** bench/fss_host.sv ***
// Host controller model that pulses sync and tracks settling per group.
module fss_host
  import fss_pkg::*;
#(
  parameter int P_SETTLE_A = 1,
  parameter int P_SETTLE_B = 1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_go,
  output logic o_sync,
  output logic o_valid_a,
  output logic o_valid_b
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic hold;
  // Sync is held high two cycles so the device always sees a clean rise.
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sync <= 1'b0;
      hold <= 1'b0;
      cnt <= -1;
    end else if (i_go) begin
      o_sync <= 1'b1;
      hold <= 1'b1;
      cnt <= 0;
    end else begin
      hold <= 1'b0;
      if (!hold) o_sync <= 1'b0;
      if (cnt >= 0) cnt <= cnt + 1;
    end
  end
  // The device sees sync one edge after it is raised here, so the period
  // settling count runs in step with cnt; valid waits for the whole settle count.
  assign o_valid_a = (cnt > P_SETTLE_A);
  assign o_valid_b = (cnt > P_SETTLE_B);
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the sync settling timer.
module tb_top import fss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SH = 4;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic go = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic [DATA_W-1:0] o_rdata;
  logic sync, restart, strobe, set_a, set_b, err;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  logic va, vb;
  int kva = 0;
  int kvb = 0;

  always #25 i_clk = ~i_clk;

  fss_timer #(.P_DELAY_SHIFT(SH)) fss_timer_i (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_sync(sync), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_filter_restart(restart),
    .o_data_ready_strobe(strobe), .o_settled_a(set_a), .o_settled_b(set_b),
    .o_cfg_err(err));
  fss_host #(.P_SETTLE_A(8822 >> SH), .P_SETTLE_B(17014 >> SH)) fss_host_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_go(go),
    .o_sync(sync), .o_valid_a(va), .o_valid_b(vb));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  function automatic int shr(input int x);
    if (x == 0) return 0;
    return ((x >> SH) == 0) ? 1 : (x >> SH);
  endfunction
  task automatic check(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, string n);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check(n, e, o_rdata);
  endtask
  // Edge numbers count the edge after the one that first samples sync high as one.
  task automatic t_cfg(input string nm, input logic [31:0] c,
                       input int f, sa, sb, per);
    int ks, k2, ka, kb;
    ks = 0;
    k2 = 0;
    ka = 0;
    kb = 0;
    kva = 0;
    kvb = 0;
    wr(OFS_CTRL, c);
    @(posedge i_clk);
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    // Restart stands only in the cycle after the edge that sees sync high.
    @(posedge i_clk);
    #1 check("restart", 1'b1, restart);
    check("flags", 2'b00, {set_a, set_b});
    @(posedge i_clk);
    #1;
    for (int k = 1; k <= 1200; k++) begin
      if (va === 1'b1 && kva == 0) kva = k;
      if (vb === 1'b1 && kvb == 0) kvb = k;
      if (strobe === 1'b1 && ks != 0 && k2 == 0) k2 = k;
      if (strobe === 1'b1 && ks == 0) ks = k;
      if (set_a === 1'b1 && ka == 0) ka = k;
      if (set_b === 1'b1 && kb == 0) kb = k;
      @(posedge i_clk);
      #1;
    end
    check("first", shr(f), ks);
    check("period", shr(per), k2 - ks);
    check("settle_a", shr(sa), ka);
    check("settle_b", shr(sb), kb);
    $display("test %s done", nm);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    check("outs", 5'h00, {restart, strobe, set_a, set_b, err});
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rchk(OFS_CTRL, CTRL_RESET, "ctrl");
    rchk(OFS_STATUS, 32'h0000_0000, "status");
    rchk(8'h40, 32'h0000_0000, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_mixed();
    t_cfg("mixed", 32'h0000_0108, 758, 8822, 17014, 128);
    check("host_valid_a", shr(8822), kva);
    check("host_valid_b", shr(17014), kvb);
    rchk(OFS_FIRST, shr(758), "first_reg");
    rchk(OFS_SETTLE_A, shr(8822), "settle_a_reg");
    rchk(OFS_SETTLE_B, shr(17014), "settle_b_reg");
    rchk(OFS_STATUS, 32'h0000_001D, "status");
  endtask
  task automatic t_resync();
    wr(OFS_CTRL, 32'h0000_0000);
    #1 check("kept", 1'b1, set_a);
    t_cfg("single", 32'h0000_0000, 336, 8400, 0, 128);
  endtask
  task automatic t_modes();
    t_cfg("sinc", 32'h0000_0004, 199, 839, 0, 128);
    t_cfg("swap", 32'h0000_0018, 759, 17015, 8823, 128);
    t_cfg("div8", 32'h0000_0001, 656, 16784, 0, 256);
  endtask
  task automatic t_invalid();
    t_cfg("bad", 32'h0000_0002, 0, 0, 0, 0);
    check("cfg_err", 1'b1, err);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    #1 t_reset();
    t_mixed();
    t_resync();
    t_modes();
    t_invalid();
    give_verdict();
  end
endmodule
